// ===== rtl/led_serial_decoder.sv
// single-wire edge counting decoder for backlight and flash control
// Functional notes
// RQ1: address 3 uses low-current backlight table
// RQ2: address 3 groups: off, sub, main, both
// RQ3: address 4 sets flash percent level
// RQ4: address 5 selects active flash sinks
// RQ5: flash enables off after startup
// RQ6: flash stays on until off/shutdown/timeout
// RQ7: address 5 reverts on timeout or strobe low
// RQ8: address 12 picks 20mA or 30mA scale
// RQ9: scale defaults to 20mA
// RQ10: main and sub share one scale
// RQ11: data 8 at address 15 sets mode
// RQ12: independent mode cleared only by shutdown
// RQ13: independent address 2 sets sinks six..three
// RQ14: independent address 3 sets sinks one, two
// RQ15: independent mode ignores address 0, old 2/3
// RQ16: other addresses unaffected by independent mode
// RQ17: strobe high forces full flash current
// RQ18: strobe rise starts timer, fall stops flash
// RQ19: timer expiry with strobe high stops flash
// RQ20: protection time is configurable parameter
// RQ21: regulator enables pass through untouched
// RQ22: edges 17+ address, 1..16 data, latched
// RQ23: low over 500us shuts down, clears all
// RQ24: address 0 all, 1 main, 2 sub
// RQ25: protection time counted in clock cycles
module led_serial_decoder
	import led_serial_pkg::*;
#(
	parameter int unsigned LATCH_CNT = LATCH_CYCLES,
	parameter int unsigned OFF_CNT   = OFF_CYCLES,
	// RQ20: protection time as parameter
	parameter int unsigned PROT_CNT  = FLASH_PROT_CYC
) (
	input  wire logic         MCLK_I,
	input  wire logic         NRST_I,
	input  wire logic         SERIAL_PULSE_LINE_I,
	input  wire logic         FLASH_STROBE_INPUT_I,
	input  wire logic         REGULATOR_A_ENABLE_I,
	input  wire logic         REGULATOR_B_ENABLE_I,
	output bl_drive_t         BACKLIGHT_O,
	output flash_drive_t      FLASH_O,
	output logic              SHUTDOWN_O,
	output logic              INDEP_MODE_O,
	output logic              REGULATOR_A_ON_O,
	output logic              REGULATOR_B_ON_O
);
	// pin synchronisers
	logic [1:0] line_sync_ff;
	logic [1:0] strobe_sync_ff;
	logic       line_d_ff;
	logic       strobe_d_ff;
	logic       line_s;
	logic       strobe_s;
	assign line_s   = line_sync_ff[1];
	assign strobe_s = strobe_sync_ff[1];

	// serial state
	logic [5:0]  edge_cnt_ff;
	logic [31:0] high_cnt_ff;
	logic [31:0] low_cnt_ff;
	logic        shutdown_ff;
	logic [3:0]  addr_ff;
	logic        wr_stb;
	logic [3:0]  wr_data;
	logic        latch_now;
	logic        off_now;

	// stored settings, codes are data minus one
	logic [3:0] main_code_ff;
	logic [3:0] sub_code_ff;
	logic [3:0] low_code_ff;
	logic       low_mode_ff;
	logic [3:0] flash_lvl_ff;
	logic [1:0] flash_en_ff;   // {sink one, sink two}
	logic       scale_ff;
	logic       indep_ff;
	logic [3:0] indep_hi_ff;   // sinks six..three
	logic [1:0] indep_lo_ff;   // sinks two, one

	// flash timer
	logic [31:0] prot_cnt_ff;
	logic        prot_run_ff;
	logic        prot_expired_ff;
	logic        strobe_rise;
	logic        strobe_fall;
	logic        prot_done;

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			line_sync_ff   <= 2'h0;
			strobe_sync_ff <= 2'h0;
			line_d_ff      <= 1'b0;
			strobe_d_ff    <= 1'b0;
		end else begin
			line_sync_ff   <= {line_sync_ff[0], SERIAL_PULSE_LINE_I};
			strobe_sync_ff <= {strobe_sync_ff[0], FLASH_STROBE_INPUT_I};
			line_d_ff      <= line_s;
			strobe_d_ff    <= strobe_s;
		end
	end

	// RQ23: shutdown on long low
	assign off_now = !line_s && (low_cnt_ff == 32'(OFF_CNT - 1));
	// RQ22: latch after long high pause
	assign latch_now = line_s && (edge_cnt_ff != 6'h00)
		&& (high_cnt_ff == 32'(LATCH_CNT - 1));

	// pulse-width counters
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			high_cnt_ff <= 32'h0;
			low_cnt_ff  <= 32'h0;
			shutdown_ff <= 1'b1;
		end else begin
			high_cnt_ff <= (line_s && !latch_now && high_cnt_ff !=
				32'(LATCH_CNT)) ? high_cnt_ff + 32'h1 : 32'h0;
			if (line_s)
				low_cnt_ff <= 32'h0;
			else if (low_cnt_ff != 32'(OFF_CNT))
				low_cnt_ff <= low_cnt_ff + 32'h1;
			if (off_now)
				shutdown_ff <= 1'b1;
			else if (line_s && !line_d_ff)
				shutdown_ff <= 1'b0;
		end
	end

	// RQ22: edge counting, address select, data write
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			edge_cnt_ff <= 6'h00;
			addr_ff     <= RST_CODE;
		end else if (off_now) begin
			edge_cnt_ff <= 6'h00;
			addr_ff     <= RST_CODE;
		end else if (latch_now) begin
			edge_cnt_ff <= 6'h00;
			if (edge_cnt_ff >= ADDR_EDGE_BASE)
				addr_ff <= 4'(edge_cnt_ff - ADDR_EDGE_BASE);
		end else if (line_s && !line_d_ff && edge_cnt_ff != 6'h3F) begin
			edge_cnt_ff <= edge_cnt_ff + 6'h01;
		end
	end

	assign wr_stb  = latch_now && (edge_cnt_ff <= DATA_EDGE_MAX);
	assign wr_data = 4'(edge_cnt_ff - 6'h01);

	// backlight settings
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			main_code_ff <= BL_OFF_CODE;
			sub_code_ff  <= BL_OFF_CODE;
			low_code_ff  <= RST_CODE;
			low_mode_ff  <= 1'b0;
			scale_ff     <= SCALE_20MA;
			indep_ff     <= 1'b0;
			indep_hi_ff  <= 4'h0;
			indep_lo_ff  <= 2'h0;
		end else if (off_now) begin
			// RQ12: only shutdown leaves the mode
			main_code_ff <= BL_OFF_CODE;
			sub_code_ff  <= BL_OFF_CODE;
			low_code_ff  <= RST_CODE;
			low_mode_ff  <= 1'b0;
			// RQ9: back to 20mA scale
			scale_ff     <= SCALE_20MA;
			indep_ff     <= 1'b0;
			indep_hi_ff  <= 4'h0;
			indep_lo_ff  <= 2'h0;
		end else if (wr_stb) begin
			case (addr_ff)
				// RQ24: all, main or sub
				ADDR_ALL_BL: begin
					// RQ15: ignored in independent mode
					if (!indep_ff) begin
						main_code_ff <= wr_data;
						sub_code_ff  <= wr_data;
						low_mode_ff  <= 1'b0;
					end
				end
				ADDR_MAIN_BL: begin
					main_code_ff <= wr_data;
					low_mode_ff  <= 1'b0;
				end
				ADDR_SUB_BL: begin
					// RQ13: sinks six..three from data bits
					if (indep_ff)
						indep_hi_ff <= wr_data;
					else begin
						sub_code_ff <= wr_data;
						low_mode_ff <= 1'b0;
					end
				end
				ADDR_LOW_BL: begin
					// RQ14: bit 3 sink two, bit 2 sink one
					if (indep_ff)
						indep_lo_ff <= wr_data[3:2];
					else begin
						// RQ1: switch to low-current table
						low_code_ff <= wr_data;
						low_mode_ff <= 1'b1;
					end
				end
				// RQ8: one scale for the whole backlight
				ADDR_FULL_SCALE: begin
					if (wr_data == 4'h0)
						scale_ff <= 1'b0;
					else if (wr_data == 4'h1)
						scale_ff <= 1'b1;
				end
				// RQ11: data 8 enters independent mode
				ADDR_INDEP: begin
					if (wr_data == INDEP_CODE)
						indep_ff <= 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// flash level and enables
	assign strobe_rise = strobe_s && !strobe_d_ff;
	assign strobe_fall = !strobe_s && strobe_d_ff;
	assign prot_done   = prot_run_ff && (prot_cnt_ff == 32'(PROT_CNT - 1));

	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			flash_lvl_ff <= RST_CODE;
			flash_en_ff  <= 2'h0;
		end else if (off_now) begin
			flash_lvl_ff <= RST_CODE;
			// RQ6: shutdown ends serial flash
			flash_en_ff  <= 2'h0;
		end else begin
			// RQ16: flash level works in any mode
			// RQ3: level code stored as data minus one
			if (wr_stb && addr_ff == ADDR_FLASH_LVL)
				flash_lvl_ff <= wr_data;
			// RQ7: revert to both off on expiry or strobe fall
			if (prot_done || strobe_fall)
				flash_en_ff <= 2'h0;
			// RQ4: data 1..4 map to both bits of data-1
			else if (wr_stb && addr_ff == ADDR_FLASH_EN
				&& wr_data[3:2] == 2'h0)
				flash_en_ff <= wr_data[1:0];
		end
	end

	// RQ25: protection timer counted in clock cycles
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			prot_cnt_ff     <= 32'h0;
			prot_run_ff     <= 1'b0;
			prot_expired_ff <= 1'b0;
		end else if (!strobe_s) begin
			prot_cnt_ff     <= 32'h0;
			prot_run_ff     <= 1'b0;
			prot_expired_ff <= 1'b0;
		end else if (strobe_rise) begin
			// RQ18: rising strobe starts timer
			prot_cnt_ff     <= 32'h0;
			prot_run_ff     <= 1'b1;
			prot_expired_ff <= 1'b0;
		end else if (prot_done) begin
			// RQ19: expiry with strobe high stops flash
			prot_run_ff     <= 1'b0;
			prot_expired_ff <= 1'b1;
		end else if (prot_run_ff) begin
			prot_cnt_ff <= prot_cnt_ff + 32'h1;
		end
	end

	// drive outputs
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			BACKLIGHT_O <= '0;
			FLASH_O     <= '0;
		end else begin
			BACKLIGHT_O.main_code   <= main_code_ff;
			BACKLIGHT_O.sub_code    <= sub_code_ff;
			// RQ10: single scale bit for main and sub
			BACKLIGHT_O.scale_30ma  <= scale_ff;
			BACKLIGHT_O.low_mode    <= low_mode_ff && !indep_ff;
			// RQ2: groups of four, level in low bits
			BACKLIGHT_O.low_level   <= low_code_ff[1:0];
			BACKLIGHT_O.low_main_on <= low_code_ff[3];
			BACKLIGHT_O.low_sub_on  <= low_code_ff[2];
			if (indep_ff)
				BACKLIGHT_O.chan_on <= {indep_hi_ff, indep_lo_ff};
			else if (low_mode_ff)
				BACKLIGHT_O.chan_on <= {low_code_ff[2],
					{5{low_code_ff[3]}}};
			else
				BACKLIGHT_O.chan_on <= {sub_code_ff != BL_OFF_CODE,
					{5{main_code_ff != BL_OFF_CODE}}};
			// RQ17: strobe forces full current on both sinks
			if (strobe_s && !prot_expired_ff && !prot_done) begin
				FLASH_O.sink_one_on <= 1'b1;
				FLASH_O.sink_two_on <= 1'b1;
				FLASH_O.level_code  <= FLASH_FULL_CODE;
				FLASH_O.percent     <= flash_percent(FLASH_FULL_CODE);
			end else begin
				// RQ5: serial enables start off
				FLASH_O.sink_one_on <= flash_en_ff[1];
				FLASH_O.sink_two_on <= flash_en_ff[0];
				FLASH_O.level_code  <= flash_lvl_ff;
				FLASH_O.percent     <= flash_percent(flash_lvl_ff);
			end
		end
	end

	// status and regulator pass-through
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			SHUTDOWN_O       <= 1'b1;
			INDEP_MODE_O     <= 1'b0;
			REGULATOR_A_ON_O <= 1'b0;
			REGULATOR_B_ON_O <= 1'b0;
		end else begin
			SHUTDOWN_O       <= shutdown_ff;
			INDEP_MODE_O     <= indep_ff;
			// RQ21: regulator enables ignore serial state
			REGULATOR_A_ON_O <= REGULATOR_A_ENABLE_I;
			REGULATOR_B_ON_O <= REGULATOR_B_ENABLE_I;
		end
	end
endmodule // led_serial_decoder

// ===== rtl/led_serial_pkg.sv
// constants and carrier types for the serial led control decoder
package led_serial_pkg;
	localparam int unsigned CLK_HZ          = 40_000_000;
	// latch and shutdown pauses in microseconds
	localparam int unsigned LATCH_US        = 500;
	localparam int unsigned OFF_US          = 500;
	localparam int unsigned LATCH_CYCLES    = (CLK_HZ / 1_000_000) * LATCH_US;
	localparam int unsigned OFF_CYCLES      = (CLK_HZ / 1_000_000) * OFF_US;
	// flash protection time in milliseconds (1 s example)
	localparam int unsigned FLASH_PROT_MS   = 1000;
	localparam int unsigned FLASH_PROT_CYC  = (CLK_HZ / 1000) * FLASH_PROT_MS;

	// register addresses
	localparam logic [3:0] ADDR_ALL_BL      = 4'h0;
	localparam logic [3:0] ADDR_MAIN_BL     = 4'h1;
	localparam logic [3:0] ADDR_SUB_BL      = 4'h2;
	localparam logic [3:0] ADDR_LOW_BL      = 4'h3;
	localparam logic [3:0] ADDR_FLASH_LVL   = 4'h4;
	localparam logic [3:0] ADDR_FLASH_EN    = 4'h5;
	localparam logic [3:0] ADDR_FULL_SCALE  = 4'hC;
	localparam logic [3:0] ADDR_INDEP       = 4'hF;

	// edge count at which addresses start
	localparam logic [5:0] ADDR_EDGE_BASE   = 6'h11;
	localparam logic [5:0] DATA_EDGE_MAX    = 6'h10;
	// data code (minus one) that enters independent mode
	localparam logic [3:0] INDEP_CODE       = 4'h7;
	// stored codes are data minus one
	localparam logic [3:0] RST_CODE         = 4'h0;
	localparam logic [3:0] BL_OFF_CODE      = 4'hF;
	localparam logic [3:0] FLASH_FULL_CODE  = 4'h0;
	localparam logic       SCALE_20MA       = 1'b0;

	// backlight drive summary
	typedef struct packed {
		logic [3:0] main_code;   // level code, data minus one
		logic [3:0] sub_code;
		logic       scale_30ma;
		logic       low_mode;    // low-current table active
		logic [1:0] low_level;   // 95/500/950/1900 uA index
		logic       low_main_on;
		logic       low_sub_on;
		logic [5:0] chan_on;     // sinks six..one
	} bl_drive_t;

	// flash drive summary
	typedef struct packed {
		logic       sink_one_on;
		logic       sink_two_on;
		logic [3:0] level_code;  // 0 = 100 percent
		logic [6:0] percent;
	} flash_drive_t;

	// flash percentage per level code
	function automatic logic [6:0] flash_percent(input logic [3:0] code);
		case (code)
			4'h0: flash_percent = 7'd100;
			4'h1: flash_percent = 7'd87;
			4'h2: flash_percent = 7'd77;
			4'h3: flash_percent = 7'd66;
			4'h4: flash_percent = 7'd58;
			4'h5: flash_percent = 7'd50;
			4'h6: flash_percent = 7'd44;
			4'h7: flash_percent = 7'd39;
			4'h8: flash_percent = 7'd35;
			4'h9: flash_percent = 7'd30;
			4'hA: flash_percent = 7'd27;
			4'hB: flash_percent = 7'd24;
			4'hC: flash_percent = 7'd20;
			4'hD: flash_percent = 7'd17;
			4'hE: flash_percent = 7'd16;
			default: flash_percent = 7'd14;
		endcase
	endfunction
endpackage

// ===== testbench/led_serial_props.sv
// assertion checker for the serial led control decoder
module led_serial_props
	import led_serial_pkg::*;
#(
	parameter int unsigned LATCH_CNT = 20,
	parameter int unsigned OFF_CNT   = 20,
	parameter int unsigned PROT_CNT  = 200
) (
	input wire logic         MCLK_I,
	input wire logic         NRST_I,
	input wire logic         SERIAL_PULSE_LINE_I,
	input wire logic         FLASH_STROBE_INPUT_I,
	input wire logic         REGULATOR_A_ENABLE_I,
	input wire logic         REGULATOR_B_ENABLE_I,
	input wire bl_drive_t    BACKLIGHT_O,
	input wire flash_drive_t FLASH_O,
	input wire logic         SHUTDOWN_O,
	input wire logic         INDEP_MODE_O,
	input wire logic         REGULATOR_A_ON_O,
	input wire logic         REGULATOR_B_ON_O
);
	int unsigned str_hi;
	int unsigned ser_hi;
	int unsigned ser_lo;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!NRST_I);
	// run lengths of raw inputs, saturating so they never wrap
	always_ff @(posedge MCLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			str_hi <= 0;
			ser_hi <= 0;
			ser_lo <= 0;
		end else begin
			str_hi <= FLASH_STROBE_INPUT_I ? str_hi + (str_hi < 9999) : 0;
			ser_hi <= SERIAL_PULSE_LINE_I ? ser_hi + (ser_hi < 9999) : 0;
			ser_lo <= SERIAL_PULSE_LINE_I ? 0 : ser_lo + (ser_lo < 9999);
		end
	end
	sequence strobe_held;
		$rose(FLASH_STROBE_INPUT_I) ##1 FLASH_STROBE_INPUT_I [*5];
	endsequence
	AST_STROBE_FULL:
	assert property (strobe_held |-> FLASH_O.sink_one_on &&
		FLASH_O.sink_two_on && FLASH_O.percent == 7'd100)
		else $error("strobe not at full current");
	AST_STROBE_OFF:
	assert property ($fell(FLASH_STROBE_INPUT_I) |-> ##[2:8]
		!FLASH_O.sink_one_on && !FLASH_O.sink_two_on)
		else $error("strobe fall left flash on");
	AST_PROT_EXPIRY:
	assert property (str_hi == PROT_CNT + 8 |->
		!FLASH_O.sink_one_on && !FLASH_O.sink_two_on)
		else $error("flash on past protection time");
	AST_SCALE_DEFAULT:
	assert property ($rose(NRST_I) |-> !BACKLIGHT_O.scale_30ma && SHUTDOWN_O)
		else $error("scale not 20mA after reset");
	AST_FLASH_CAUSE:
	assert property ($rose(FLASH_O.sink_one_on) |->
		FLASH_STROBE_INPUT_I || ser_hi >= LATCH_CNT)
		else $error("flash on without strobe or write");
	AST_SHUTDOWN:
	assert property (ser_lo == OFF_CNT + 8 |-> SHUTDOWN_O && !INDEP_MODE_O
		&& !BACKLIGHT_O.scale_30ma)
		else $error("no shutdown after long low");
	AST_INDEP_KEEP:
	assert property ($fell(INDEP_MODE_O) |-> ser_lo >= OFF_CNT)
		else $error("mode left without shutdown");
	AST_INDEP_LATCH:
	assert property ($rose(INDEP_MODE_O) |-> ser_hi >= LATCH_CNT)
		else $error("mode set before latch pause");
	AST_REG_PASS:
	assert property ($past(NRST_I) |->
		REGULATOR_A_ON_O == $past(REGULATOR_A_ENABLE_I) &&
		REGULATOR_B_ON_O == $past(REGULATOR_B_ENABLE_I))
		else $error("regulator enable not passed");
endmodule // led_serial_props

// ===== testbench/serial_host.sv
// host model: pulses the serial line and drives the strobe
module serial_host #(
	parameter int LATCH = 20,
	parameter int OFF   = 20
) (
	input  wire logic clk_i,
	output logic      line_o,
	output logic      strobe_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// line starts low, so the device begins shut down
	initial begin
		line_o = 1'b0;
		strobe_o = 1'b0;
	end
	task automatic burst(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_i) line_o = 1'b0;
			repeat (3 + $urandom_range(2)) @(negedge clk_i);
			line_o = 1'b1;
			repeat (3 + $urandom_range(2)) @(negedge clk_i);
		end
		repeat (LATCH + 8) @(negedge clk_i);
	endtask
	task automatic off();
		@(negedge clk_i) line_o = 1'b0;
		repeat (OFF + 12) @(negedge clk_i);
	endtask
	task automatic strobe(input logic v);
		@(negedge clk_i) strobe_o = v;
	endtask
endmodule // serial_host

// ===== testbench/tb.sv
// self-checking bench for the serial led control decoder
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import led_serial_pkg::*;
	localparam int LAT = 20;
	localparam int OFF = 20;
	localparam int PROT = 200;
	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         reg_a = 1'b0;
	logic         reg_b = 1'b0;
	logic         line, strobe, shut, indep, a_on, b_on;
	bl_drive_t    bl;
	flash_drive_t fl;
	int           num_errors = 0;
	int           n_compared = 0;
	int           m_addr;
	logic [3:0]   m_main, m_sub, m_lvl;
	logic         m_scale, m_indep, m_fl1, m_fl2, m_low, m_chok;
	logic [5:0]   m_chan;
	logic [7:0]   pct [16] = '{8'd100, 8'd87, 8'd77, 8'd66, 8'd58, 8'd50,
		8'd44, 8'd39, 8'd35, 8'd30, 8'd27, 8'd24, 8'd20, 8'd17, 8'd16, 8'd14};
	always #12.5 clk = ~clk;
	serial_host #(.LATCH(LAT), .OFF(OFF)) host (.clk_i(clk), .line_o(line),
		.strobe_o(strobe));
	led_serial_decoder #(.LATCH_CNT(LAT), .OFF_CNT(OFF), .PROT_CNT(PROT)) dut (
		.MCLK_I(clk), .NRST_I(rst_n), .SERIAL_PULSE_LINE_I(line),
		.FLASH_STROBE_INPUT_I(strobe), .REGULATOR_A_ENABLE_I(reg_a),
		.REGULATOR_B_ENABLE_I(reg_b), .BACKLIGHT_O(bl), .FLASH_O(fl),
		.SHUTDOWN_O(shut), .INDEP_MODE_O(indep),
		.REGULATOR_A_ON_O(a_on), .REGULATOR_B_ON_O(b_on));
	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %0h seen %0h", nm, e, s);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// model state after reset or shutdown
	task automatic clr();
		m_addr = 0;
		m_main = 4'hF;
		m_sub = 4'hF;
		m_lvl = 4'h0;
		{m_scale, m_indep, m_fl1, m_fl2, m_low, m_chok} = 6'h00;
	endtask
	task automatic chk_all();
		chk("scale", bl.scale_30ma, m_scale);
		chk("indep", indep, m_indep);
		chk("fl", {fl.sink_one_on, fl.sink_two_on}, {m_fl1, m_fl2});
		chk("fl_lvl", fl.level_code, m_lvl);
		chk("fl_pct", fl.percent, pct[m_lvl]);
		if (!m_low) chk("main", bl.main_code, m_main);
		if (!m_low) chk("sub", bl.sub_code, m_sub);
		if (m_chok) chk("chan", bl.chan_on, m_chan);
		if (!m_indep && !m_low) chk("chan_n", bl.chan_on, {m_sub != 4'hF, {5{m_main != 4'hF}}});
		chk("reg", {a_on, b_on}, {reg_a, reg_b});
	endtask
	// one serial write; address skipped when a is negative
	task automatic wr(input int a, input int d);
		logic [3:0] c;
		c = 4'(d - 1);
		@(negedge clk);
		{reg_a, reg_b} = 2'($urandom);
		if (a >= 0) host.burst(a + 17);
		if (a >= 0) m_addr = a;
		host.burst(d);
		case (m_addr)
			0: if (!m_indep) {m_main, m_sub, m_low} = {c, c, 1'b0};
			1: {m_main, m_low} = {c, 1'b0};
			2: if (m_indep) m_chan[5:2] = c;
				else {m_sub, m_low} = {c, 1'b0};
			3: if (m_indep) begin
				m_chan[1:0] = c[3:2];
				m_chok = 1'b1;
			end else begin
				m_low = 1'b1;
				chk("low", {bl.low_mode, bl.low_main_on, bl.low_sub_on},
					{1'b1, c[3:2]});
				chk("low_lvl", bl.low_level, c[1:0]);
			end
			4: m_lvl = c;
			5: if (d <= 4) {m_fl1, m_fl2} = c[1:0];
			12: if (d == 1 || d == 2) m_scale = c[0];
			15: if (d == 8) m_indep = 1'b1;
			default: ;
		endcase
		chk_all();
	endtask
	task automatic off_chk();
		host.off();
		chk("shut", shut, 1'b1);
		chk("indep", indep, 1'b0);
		clr();
	endtask
	// main sequence
	initial begin
		void'($urandom(32'hBCAAD43B));
		clr();
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk("shut", shut, 1'b1);
		chk_all();
		wr(-1, 1 + $urandom_range(15));
		wr(1, 3);
		wr(2, 16);
		wr(12, 2);
		wr(12, 3);
		wr(12, 1);
		for (int i = 1; i <= 16; i++) wr(4, i);
		for (int i = 1; i <= 5; i++) wr(5, i);
		wr(4, 1 + $urandom_range(15));
		host.strobe(1'b1);
		repeat (8) @(negedge clk);
		chk("fen", {fl.sink_one_on, fl.sink_two_on, fl.level_code}, 6'h30);
		chk("fen_pct", fl.percent, 8'd100);
		host.strobe(1'b0);
		repeat (8) @(negedge clk);
		{m_fl1, m_fl2} = 2'b00;
		chk_all();
		wr(5, 3);
		host.strobe(1'b1);
		repeat (PROT + 10) @(negedge clk);
		chk("fen_to", {fl.sink_one_on, fl.sink_two_on}, 2'b00);
		host.strobe(1'b0);
		repeat (8) @(negedge clk);
		{m_fl1, m_fl2} = 2'b00;
		chk_all();
		for (int i = 0; i < 4; i++) wr(3, 1 + 4 * i + $urandom_range(3));
		off_chk();
		wr(-1, 1 + $urandom_range(15));
		wr(15, 7);
		wr(15, 8);
		wr(0, 4);
		wr(2, 1 + $urandom_range(15));
		wr(3, 1 + $urandom_range(15));
		wr(12, 2);
		wr(5, 4);
		off_chk();
		end_of_test();
	end
	// watchdog against a hung handshake
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
endmodule // tb
bind led_serial_decoder led_serial_props #(.LATCH_CNT(LATCH_CNT),
	.OFF_CNT(OFF_CNT), .PROT_CNT(PROT_CNT)) props (.MCLK_I(MCLK_I),
	.NRST_I(NRST_I), .SERIAL_PULSE_LINE_I(SERIAL_PULSE_LINE_I),
	.FLASH_STROBE_INPUT_I(FLASH_STROBE_INPUT_I),
	.REGULATOR_A_ENABLE_I(REGULATOR_A_ENABLE_I),
	.REGULATOR_B_ENABLE_I(REGULATOR_B_ENABLE_I), .BACKLIGHT_O(BACKLIGHT_O),
	.FLASH_O(FLASH_O), .SHUTDOWN_O(SHUTDOWN_O), .INDEP_MODE_O(INDEP_MODE_O),
	.REGULATOR_A_ON_O(REGULATOR_A_ON_O), .REGULATOR_B_ON_O(REGULATOR_B_ON_O));
